// >>> verilog/dfchk_pkg.sv
// Package: constants and types for the disk file check logic
package dfchk_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 25;
  localparam int RESP8_NS = 12000;
  localparam int RESP6_NS = 8800;
  // Longest wait rounds down to whole cycles
  localparam int RESP8_CYC = (RESP8_NS * CLK_MHZ) / 1000;
  localparam int RESP6_CYC = (RESP6_NS * CLK_MHZ) / 1000;
  localparam int TMR_W = 10;
  localparam int STOP_LEAD_CHARS = 11;
  localparam int CHAR_CNT_W = 4;
  // Layout character codes allowed during format operations
  localparam logic [5:0] LAYOUT_CODE_1 = 6'h01;
  localparam logic [5:0] LAYOUT_CODE_4 = 6'h04;
  // Highest legal control order code
  localparam logic [5:0] ORDER_MAX = 6'h0F;
  localparam logic [5:0] ORDER_PREP_VERIFY = 6'h01;
  localparam logic [5:0] ORDER_PREP_FORMAT = 6'h02;
  localparam int FLAG_W = 14;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 14'h0000;
  // Flag positions in the sense word
  localparam int F_BYTE_CHECK = 0;
  localparam int F_RESP_TIMEOUT = 1;
  localparam int F_VERIFY_MISMATCH = 2;
  localparam int F_LAYOUT_CHAR = 3;
  localparam int F_MISSING_ENTRY = 4;
  localparam int F_ORDER_VIOLATION = 5;
  localparam int F_INVALID_CMD = 6;
  localparam int F_ACCESS_INOP = 7;
  localparam int F_ACCESS_NOT_READY = 8;
  localparam int F_NOT_READY = 9;
  localparam int F_FRAME_FAULT = 10;
  localparam int F_ADAPTER_FAULT = 11;
  localparam int F_RSVD0 = 12;
  localparam int F_RSVD1 = 13;

  typedef enum logic [1:0] {
    DFCHK_OP_IDLE,
    DFCHK_OP_READ,
    DFCHK_OP_WRITE,
    DFCHK_OP_CONTROL
  } dfchk_op_type;
endpackage

// >>> verilog/dfchk_resp_if.sv
// Interface: service request timing between check top and response timer
`timescale 1ns/100ps
`default_nettype none
interface dfchk_resp_if;
  logic req_start;
  logic resp;
  logic eight_bit;
  logic timeout;
  modport top (output req_start, output resp, output eight_bit, input timeout);
  modport tmr (input req_start, input resp, input eight_bit, output timeout);
endinterface
`default_nettype wire

// >>> verilog/dfchk_resp_timer.sv
// Response timer: flags a late service response
`timescale 1ns/100ps
`default_nettype none
module dfchk_resp_timer
  import dfchk_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Async reset
  dfchk_resp_if.tmr bus // Request and response events
);
  import dfchk_pkg::*;

  localparam logic [TMR_W-1:0] LIM8 = TMR_W'(RESP8_CYC);
  localparam logic [TMR_W-1:0] LIM6 = TMR_W'(RESP6_CYC);

  if (RESP8_CYC >= (1 << TMR_W) || RESP6_CYC < 1) begin : g_bad_width
    $error("dfchk_resp_timer: timer width too small");
  end

  logic busy_q;
  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] lim;

  assign lim = bus.eight_bit ? LIM8 : LIM6;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else if (bus.req_start) begin
      busy_q <= 1'b1;
      cnt_q <= '0;
    end else if (bus.resp || bus.timeout) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Expires one pulse when the wait passes the mode limit
  assign bus.timeout = busy_q && !bus.resp && (cnt_q >= lim); // RL3 RL4
endmodule
`default_nettype wire

// >>> verilog/dfchk_format_mon.sv
// Format monitor: layout character and stop-before-index checks
`timescale 1ns/100ps
`default_nettype none
module dfchk_format_mon
  import dfchk_pkg::*;
(
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Async reset
  input wire logic i_active, // Format write or verify running
  input wire logic i_char_valid, // Character strobe
  input wire logic [5:0] i_char, // Received character
  input wire logic i_stop, // Stop from host
  input wire logic i_early_index, // Early index from disk
  output logic o_error // One-cycle layout error
);
  import dfchk_pkg::*;

  // Characters seen since the last stop
  logic [CHAR_CNT_W-1:0] since_stop_q;
  logic stopped_q;
  logic bad_char;
  logic late_stop;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stopped_q <= 1'b0;
    end else if (!i_active) begin
      stopped_q <= 1'b0;
    end else if (i_stop) begin
      stopped_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      since_stop_q <= '0;
    end else if (!i_active || i_stop) begin
      since_stop_q <= '0;
    end else if (i_char_valid && stopped_q && since_stop_q != '1) begin
      since_stop_q <= since_stop_q + 1'b1;
    end
  end

  assign bad_char = i_active && i_char_valid && !i_stop &&
                    !stopped_q && (i_char < LAYOUT_CODE_1 || i_char > LAYOUT_CODE_4); // RL6
  // Stop must lead the early index by the full character count
  assign late_stop = i_active && i_early_index &&
                     (!stopped_q || 32'(since_stop_q) < STOP_LEAD_CHARS); // RL7

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_error <= 1'b0;
    end else begin
      o_error <= bad_char || late_stop;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/dfchk_top.sv
// Top: error detection and sense flags of the disk file controller
// Operation
// RL1: Host byte with even count of ones sets the byte check error.
// RL2: Regenerated check characters mismatching while reading sets byte check error (code checks during writes too).
// RL3: Eight-bit mode: no service response within 12 us sets timeout flag.
// RL4: Six-bit mode: no service response within 8.8 us sets timeout flag.
// RL5: Write-verify data compare mismatch sets the verify mismatch flag.
// RL6: Format operation character outside codes 1 to 4 sets layout error (code checks only characters before the stop).
// RL7: Stop not sent 11 characters before early index sets layout error.
// RL8: Address of previous control order not found sets missing entry flag.
// RL9: Write without prior prepare-verify or prepare-format order sets order violation.
// RL10: Read without prior prepare-verify order sets order violation.
// RL11: Illegal control order code sets the invalid command flag.
// RL12: No access-operative answer from addressed arm unit sets access inoperative.
// RL13: Addressed access still seeking sets access not ready.
// RL14: Header operation with header enable off sets not-ready, op suppressed.
// RL15: Any check raises unusual end to host and latches its flag.
// RL16: Writing with monitor on and read safety asserted sets frame fault.
// RL17: Reading with monitor on and write safety asserted sets frame fault.
// RL18: Monitor on before any safety line sets frame fault; correct lines do not.
// RL19: Access-operative line failing before or after selection sets frame fault (code checks only during selection and the cycle after).
// RL20: Ready line failing before arm unit selection sets frame fault.
// RL21: Amplifier, driver failure or skew abort of write sets frame fault.
// RL22: Gap tolerance or compare, generator, skew, timing failure sets adapter fault (code checks gap tolerance only during a format verify).
// RL23: End response clears command triggers, end and unusual end.
// RL24: Flags stay latched until next command or system reset.
`timescale 1ns/100ps
`default_nettype none
module dfchk_top
  import dfchk_pkg::*;
(
  input wire logic i_clk, // 25 MHz clock
  input wire logic i_rst, // Async reset, high
  input wire logic i_sys_reset, // System reset line from host
  input wire logic i_read_cmd, // Read command pulse
  input wire logic i_write_cmd, // Write command pulse
  input wire logic i_control_cmd, // Control command pulse
  input wire logic i_sense_cmd, // Sense command pulse
  input wire logic i_end_response, // End response from host
  input wire logic i_byte_valid, // Host byte strobe
  input wire logic [7:0] i_byte, // Host byte data
  input wire logic i_byte_parity, // Host byte parity bit
  input wire logic i_order_valid, // Control order code strobe
  input wire logic [5:0] i_order_code, // Control order code
  input wire logic i_eight_bit, // Eight-bit transfer mode
  input wire logic i_svc_req, // Service request issued
  input wire logic i_svc_resp, // Service response received
  input wire logic i_format_op, // Format write or verify running
  input wire logic i_verify_op, // Write-verify operation running
  input wire logic i_header_op, // Track header operation attempted
  input wire logic i_header_enable, // Operator header-enable switch
  input wire logic i_stop, // Stop from host
  input wire logic i_early_index, // Early index from disk
  input wire logic i_check_char_fail, // Regenerated check chars differ
  input wire logic i_compare_fail, // Verify data differs
  input wire logic i_addr_not_found, // Track search ended without match
  input wire logic i_arm_select, // Arm control unit selected
  input wire logic i_arm_timeout, // No access-operative answer in time
  input wire logic i_seeking, // Access still moving
  input wire logic i_monitor, // Monitor trigger
  input wire logic i_read_safety, // Read safety from disk
  input wire logic i_write_safety, // Write safety from disk
  input wire logic i_access_ready, // Ready line from disk
  input wire logic i_access_operative, // Access-operative line
  input wire logic i_amp_fail, // Read amplifier or write driver failure
  input wire logic i_skew_abort, // Skew detector aborted a write
  input wire logic i_gap_tol_fail, // Gap detection out of tolerance
  input wire logic i_circuit_fail, // Compare, generator, skew or ring failure
  output logic [FLAG_W-1:0] o_sense_flags, // Latched check flags
  output logic o_unusual_end, // Unusual end to host
  output logic o_not_ready, // Not-ready condition
  output logic o_header_go, // Header operation allowed
  output dfchk_op_type o_op // Active command trigger
);
  import dfchk_pkg::*;

  // ************************************************
  // Command triggers
  // ************************************************
  dfchk_op_type op_q;
  logic sense_q;
  logic new_cmd;
  logic prep_verify_q;
  logic prep_format_q;

  assign new_cmd = i_read_cmd || i_write_cmd || i_control_cmd || i_sense_cmd;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      op_q <= DFCHK_OP_IDLE;
      sense_q <= 1'b0;
    end else if (i_sys_reset || i_end_response) begin
      op_q <= DFCHK_OP_IDLE; // RL23
      sense_q <= 1'b0; // RL23
    end else if (new_cmd) begin
      sense_q <= i_sense_cmd;
      case (1'b1)
        i_read_cmd: op_q <= DFCHK_OP_READ;
        i_write_cmd: op_q <= DFCHK_OP_WRITE;
        i_control_cmd: op_q <= DFCHK_OP_CONTROL;
        default: op_q <= DFCHK_OP_IDLE;
      endcase
    end
  end

  assign o_op = op_q;

  function automatic logic order_legal(input logic [5:0] code);
    order_legal = (code <= ORDER_MAX);
  endfunction

  // Prepare orders are remembered until consumed by the data command, replaced by the next legal order or cleared by system reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prep_verify_q <= 1'b0;
      prep_format_q <= 1'b0;
    end else if (i_sys_reset) begin
      prep_verify_q <= 1'b0;
      prep_format_q <= 1'b0;
    end else if (i_order_valid && order_legal(i_order_code)) begin
      prep_verify_q <= (i_order_code == ORDER_PREP_VERIFY);
      prep_format_q <= (i_order_code == ORDER_PREP_FORMAT);
    end else if (i_read_cmd || i_write_cmd) begin
      prep_verify_q <= 1'b0;
      prep_format_q <= 1'b0;
    end
  end

  // ************************************************
  // Sub-checks
  // ************************************************
  dfchk_resp_if resp_bus ();
  logic resp_timeout;
  logic layout_err;
  logic data_phase;

  assign data_phase = (op_q == DFCHK_OP_READ) || (op_q == DFCHK_OP_WRITE);
  assign resp_bus.req_start = i_svc_req && data_phase;
  assign resp_bus.resp = i_svc_resp;
  assign resp_bus.eight_bit = i_eight_bit;
  assign resp_timeout = resp_bus.timeout;

  dfchk_resp_timer u_resp_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .bus(resp_bus)
  );

  dfchk_format_mon u_format_mon (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_active(i_format_op),
    .i_char_valid(i_byte_valid),
    .i_char(i_byte[5:0]),
    .i_stop(i_stop),
    .i_early_index(i_early_index),
    .o_error(layout_err)
  );

  // ************************************************
  // Disk line checks
  // ************************************************
  logic sel_q;
  logic mon_q;
  logic frame_fault;
  logic safety_wrong;
  logic safety_missing;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_q <= 1'b0;
      mon_q <= 1'b0;
    end else begin
      sel_q <= i_arm_select;
      mon_q <= i_monitor;
    end
  end

  // Wrong safety line for the direction of transfer
  assign safety_wrong = i_monitor &&
    (((op_q == DFCHK_OP_WRITE) && i_read_safety) || // RL16
     ((op_q == DFCHK_OP_READ) && i_write_safety)); // RL17
  // Monitor turning on before either safety line is up
  assign safety_missing = i_monitor && !mon_q && data_phase &&
                          !i_read_safety && !i_write_safety; // RL18

  // Disk lines other than amplifier failure are watched only while a command is active
  assign frame_fault = safety_wrong || safety_missing ||
    ((op_q != DFCHK_OP_IDLE) && !i_access_operative &&
     (i_arm_select || sel_q)) || // RL19
    ((op_q != DFCHK_OP_IDLE) && !i_arm_select && !i_access_ready) || // RL20
    i_amp_fail || (i_skew_abort && op_q == DFCHK_OP_WRITE); // RL21

  // ************************************************
  // Event collection
  // ************************************************
  logic [FLAG_W-1:0] events;
  logic [FLAG_W-1:0] flags_q;
  logic header_block;

  assign header_block = i_header_op && !i_header_enable; // RL14
  assign o_header_go = i_header_op && i_header_enable;

  always_comb begin
    events = '0;
    events[F_BYTE_CHECK] = (i_byte_valid && !(^{i_byte, i_byte_parity})) || // RL1
                           (data_phase && i_check_char_fail); // RL2
    events[F_RESP_TIMEOUT] = resp_timeout; // RL3 RL4
    events[F_VERIFY_MISMATCH] = i_verify_op && i_compare_fail; // RL5
    events[F_LAYOUT_CHAR] = layout_err; // RL6 RL7
    events[F_MISSING_ENTRY] = i_addr_not_found; // RL8
    events[F_ORDER_VIOLATION] = (i_write_cmd && !prep_verify_q && !prep_format_q) || // RL9
                                (i_read_cmd && !prep_verify_q); // RL10
    events[F_INVALID_CMD] = i_order_valid && !order_legal(i_order_code); // RL11
    events[F_ACCESS_INOP] = i_arm_select && i_arm_timeout; // RL12
    events[F_ACCESS_NOT_READY] = i_arm_select && i_seeking; // RL13
    events[F_NOT_READY] = header_block; // RL14
    events[F_FRAME_FAULT] = frame_fault;
    events[F_ADAPTER_FAULT] = (i_format_op && i_verify_op && i_gap_tol_fail) ||
                              i_circuit_fail; // RL22
  end

  // A new command other than sense clears the latch; an event in the same cycle still sets
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_q <= FLAGS_RESET;
    end else if (i_sys_reset) begin
      // Set wins, in step with the unusual end line
      flags_q <= FLAGS_RESET | events; // RL24
    end else if (new_cmd && !i_sense_cmd) begin
      flags_q <= events; // RL24
    end else begin
      flags_q <= flags_q | events; // RL15
    end
  end

  assign o_sense_flags = flags_q;
  assign o_not_ready = flags_q[F_NOT_READY];

  // ************************************************
  // Unusual end
  // ************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_unusual_end <= 1'b0;
    end else if (|events) begin
      o_unusual_end <= 1'b1; // RL15
    end else if (i_sys_reset || i_end_response) begin
      o_unusual_end <= 1'b0; // RL23
    end
  end
endmodule
`default_nettype wire

// >>> test/dfchk_host_model.sv
// Host channel model: answers each service request after a set delay
`timescale 1ns/100ps
`default_nettype none
module dfchk_host_model (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Async reset
  input wire logic i_svc_req, // Request pulse
  input wire logic [9:0] i_delay, // Answer delay, zero never answers
  output logic o_svc_resp // Response pulse
);
  logic [9:0] cnt_q;
  // A silent host or a delay beyond the mode limit provokes the timeout
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 10'h000;
      o_svc_resp <= 1'b0;
    end else begin
      o_svc_resp <= (cnt_q == 10'h001);
      if (i_svc_req) begin
        cnt_q <= i_delay;
      end else if (cnt_q != 10'h000) begin
        cnt_q <= cnt_q - 10'h001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/dfchk_properties.sv
// Checker: port-level properties of the disk file check logic
`timescale 1ns/100ps
`default_nettype none
module dfchk_properties
  import dfchk_pkg::*;
(
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_sys_reset, // System reset
  input wire logic i_read_cmd, // Read start
  input wire logic i_write_cmd, // Write start
  input wire logic i_control_cmd, // Control start
  input wire logic i_end_response, // End response
  input wire logic i_byte_valid, // Byte strobe
  input wire logic [7:0] i_byte, // Byte
  input wire logic i_byte_parity, // Parity
  input wire logic i_verify_op, // Verify running
  input wire logic i_compare_fail, // Compare fail
  input wire logic i_addr_not_found, // Search miss
  input wire logic i_header_op, // Header op
  input wire logic i_header_enable, // Header switch
  input wire logic [FLAG_W-1:0] o_sense_flags, // Flags
  input wire logic o_unusual_end, // Unusual end
  input wire logic o_not_ready, // Not ready
  input wire logic o_header_go, // Header allowed
  input wire dfchk_op_type o_op // Command trigger
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Commands and system reset are the only legal ways to drop a flag
  sequence s_calm;
    !i_sys_reset && !i_read_cmd && !i_write_cmd && !i_control_cmd;
  endsequence
  sequence s_flag(int b);
    o_sense_flags[b] && o_unusual_end;
  endsequence
  property p_byte;
    i_byte_valid && !i_sys_reset && !(^{i_byte, i_byte_parity}) |=> s_flag(F_BYTE_CHECK);
  endproperty
  a_byte: assert property (p_byte) else $error("byte check flag missing");
  property p_mism;
    i_compare_fail && i_verify_op && !i_sys_reset |=> s_flag(F_VERIFY_MISMATCH);
  endproperty
  a_mism: assert property (p_mism) else $error("mismatch flag missing");
  property p_miss;
    i_addr_not_found && !i_sys_reset |=> s_flag(F_MISSING_ENTRY);
  endproperty
  a_miss: assert property (p_miss) else $error("missing entry flag missing");
  property p_hdr_go;
    o_header_go == (i_header_op && i_header_enable);
  endproperty
  a_hdr_go: assert property (p_hdr_go) else $error("header go wrong");
  property p_nrdy;
    i_header_op && !i_header_enable && !i_sys_reset |=> o_not_ready && o_unusual_end;
  endproperty
  a_nrdy: assert property (p_nrdy) else $error("not ready missing");
  property p_hold;
    s_calm |=> (o_sense_flags & $past(o_sense_flags)) == $past(o_sense_flags);
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
  property p_end;
    i_end_response ##0 s_calm |=> o_op == DFCHK_OP_IDLE;
  endproperty
  a_end: assert property (p_end) else $error("trigger kept after end");
  property p_ue;
    $rose(|o_sense_flags) |-> o_unusual_end;
  endproperty
  a_ue: assert property (p_ue) else $error("unusual end missing");
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the disk file check logic
`timescale 1ns/100ps
`default_nettype none
`define CHECK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
  import dfchk_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_sys_reset = 1'b0, i_read_cmd = 1'b0;
  logic i_write_cmd = 1'b0, i_control_cmd = 1'b0, i_sense_cmd = 1'b0, i_end_response = 1'b0;
  logic i_byte_valid = 1'b0, i_byte_parity = 1'b0, i_order_valid = 1'b0, i_eight_bit = 1'b0;
  logic i_svc_req = 1'b0, i_format_op = 1'b0, i_header_op = 1'b0, i_header_enable = 1'b1;
  logic i_stop = 1'b0, i_early_index = 1'b0, i_arm_select = 1'b0, i_monitor = 1'b0;
  logic i_read_safety = 1'b0, i_write_safety = 1'b0, i_svc_resp;
  logic [7:0] i_byte = 8'h00;
  logic [5:0] i_order_code = 6'h00;
  logic [10:0] ev = 11'h000;
  logic [9:0] dly = 10'h000;
  logic [FLAG_W-1:0] o_sense_flags;
  logic o_unusual_end, o_not_ready, o_header_go;
  dfchk_op_type o_op;
  logic [FLAG_W+2:0] expq[$];
  logic [FLAG_W+2:0] ex;
  int n_errors = 0, check_count = 0, lim;
  localparam int EVB[11] = '{F_BYTE_CHECK, F_VERIFY_MISMATCH, F_MISSING_ENTRY,
    F_ACCESS_INOP, F_ACCESS_NOT_READY, F_FRAME_FAULT, F_FRAME_FAULT, F_ADAPTER_FAULT,
    F_ADAPTER_FAULT, F_FRAME_FAULT, F_FRAME_FAULT};
  dfchk_top dfchk_top_inst (.i_check_char_fail(ev[0]), .i_compare_fail(ev[1]),
    .i_verify_op(ev[1] || ev[7]), .i_addr_not_found(ev[2]), .i_arm_timeout(ev[3]),
    .i_seeking(ev[4]),
    .i_amp_fail(ev[5]), .i_skew_abort(ev[6]), .i_gap_tol_fail(ev[7]), .i_circuit_fail(ev[8]),
    .i_access_ready(!ev[9]), .i_access_operative(!ev[10]), .*);
  dfchk_host_model dfchk_host_model_inst (.i_clk(i_clk), .i_rst(i_rst), .i_svc_req(i_svc_req),
    .i_delay(dly), .o_svc_resp(i_svc_resp));
  always #20 i_clk = ~i_clk;
  // Pre-edge values are read, so the outputs of the last edge are settled
  always @(posedge i_clk) begin
    if (expq.size() != 0) begin
      ex = expq.pop_front();
      `CHECK({o_op, o_unusual_end, o_sense_flags}, ex)
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic put(input dfchk_op_type o, input logic u, input int b);
    expq.push_back({o, u, (b < 0) ? FLAG_W'(0) : FLAG_W'(1) << b});
    cyc(1);
  endtask
  task automatic clr();
    {i_format_op, i_header_op, i_monitor, i_read_safety, i_write_safety, i_arm_select} = '0;
    i_header_enable = 1'b1;
    pulse(i_sys_reset);
  endtask
  task automatic order(input logic [5:0] c);
    pulse(i_control_cmd);
    i_order_code = c;
    pulse(i_order_valid);
  endtask
  task automatic chr(input logic [5:0] c);
    i_byte = {2'b00, c};
    i_byte_parity = ~^i_byte;
    pulse(i_byte_valid);
  endtask
  task automatic results();
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge i_clk);
    n_errors++;
    results();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(32'h6DB262FD));
    repeat (12) @(posedge i_clk);
    cyc(1);
    i_rst = 1'b0;
    cyc(1);
    for (int k = 0; k < 8; k++) begin
      clr();
      i_byte = 8'($urandom);
      i_byte_parity = (k < 4) ? ~^i_byte : ^i_byte;
      pulse(i_byte_valid);
      put(DFCHK_OP_IDLE, k >= 4, (k >= 4) ? F_BYTE_CHECK : -1);
    end
    for (int k = 0; k < 11; k++) begin
      clr();
      // Check characters and skew abort only count inside a data transfer
      if (k == 0) order(ORDER_PREP_VERIFY);
      if (k == 6) order(ORDER_PREP_FORMAT);
      if (k == 0) pulse(i_read_cmd);
      else if (k == 6) pulse(i_write_cmd);
      else pulse(i_control_cmd);
      // Arm checks need a selected unit; gap check needs a format verify
      i_arm_select = (k == 3 || k == 4 || k == 10);
      i_format_op = (k == 7);
      ev[k] = 1'b1;
      cyc(1);
      ev = '0;
      put((k == 0) ? DFCHK_OP_READ : (k == 6) ? DFCHK_OP_WRITE : DFCHK_OP_CONTROL, 1'b1,
        EVB[k]);
    end
    for (int k = 0; k < 4; k++) begin
      clr();
      i_eight_bit = k[1];
      lim = k[1] ? RESP8_CYC : RESP6_CYC;
      dly = k[0] ? 10'(lim - 5) : 10'h000;
      order(ORDER_PREP_VERIFY);
      pulse(i_read_cmd);
      pulse(i_svc_req);
      cyc(lim + 6);
      put(DFCHK_OP_READ, !k[0], k[0] ? -1 : F_RESP_TIMEOUT);
    end
    for (int k = 0; k < 5; k++) begin
      clr();
      if (k != 0) order(k[0] ? ORDER_PREP_FORMAT : ORDER_PREP_VERIFY);
      if (k[1]) pulse(i_read_cmd); else pulse(i_write_cmd);
      cyc(1);
      put(k[1] ? DFCHK_OP_READ : DFCHK_OP_WRITE, k == 0 || k == 3,
        (k == 0 || k == 3) ? F_ORDER_VIOLATION : -1);
    end
    for (int k = 0; k < 64; k++) begin
      clr();
      order(6'(k));
      put(DFCHK_OP_CONTROL, k > ORDER_MAX, (k > ORDER_MAX) ? F_INVALID_CMD : -1);
    end
    for (int k = 0; k < 4; k++) begin
      clr();
      order(ORDER_PREP_FORMAT);
      pulse(i_write_cmd);
      i_format_op = 1'b1;
      for (int j = 1; j <= 4; j++) chr(6'(j));
      if (k == 1) chr(6'(5 + $urandom % 59));
      if (k != 3) pulse(i_stop);
      for (int j = 0; j < (k == 2 ? 10 : 11); j++) chr(6'(1 + j % 4));
      pulse(i_early_index);
      cyc(2);
      put(DFCHK_OP_WRITE, k != 0, (k != 0) ? F_LAYOUT_CHAR : -1);
    end
    for (int k = 0; k < 5; k++) begin
      clr();
      order(k[1] ? ORDER_PREP_VERIFY : ORDER_PREP_FORMAT);
      if (k[1]) pulse(i_read_cmd); else pulse(i_write_cmd);
      i_write_safety = (k == 0 || k == 3);
      i_read_safety = (k == 1 || k == 2);
      cyc(1);
      i_monitor = 1'b1;
      cyc(2);
      put(k[1] ? DFCHK_OP_READ : DFCHK_OP_WRITE, k[0] || k[2],
        (k[0] || k[2]) ? F_FRAME_FAULT : -1);
    end
    clr();
    i_header_enable = 1'b0;
    i_header_op = 1'b1;
    cyc(1);
    i_header_op = 1'b0;
    pulse(i_sense_cmd);
    pulse(i_end_response);
    put(DFCHK_OP_IDLE, 1'b0, F_NOT_READY);
    pulse(i_control_cmd);
    put(DFCHK_OP_CONTROL, 1'b0, -1);
    pulse(i_end_response);
    put(DFCHK_OP_IDLE, 1'b0, -1);
    cyc(2);
    results();
  end
endmodule
bind dfchk_top dfchk_properties dfchk_properties_inst (.*);
`default_nettype wire
